//--- shared/pscr_defs.vh
`ifndef PSCR_DEFS_VH
`define PSCR_DEFS_VH

// data-space offsets
`define PSCR_OFS_SLEEP_CTRL   8'h53
`define PSCR_OFS_SYS_CTRL     8'h55
`define PSCR_OFS_GATE_2       8'h63
`define PSCR_OFS_GATE_0       8'h64
`define PSCR_OFS_GATE_1       8'h65
// i/o-space addresses sit this far below data space
`define PSCR_IO_OFFSET        8'h20

// reset values
`define PSCR_RST_SLEEP_CTRL   8'h00
`define PSCR_RST_SYS_CTRL     8'h00
`define PSCR_RST_GATE         8'h00

// sleep control fields
`define PSCR_SE_BIT           0
`define PSCR_SM_LSB           1
`define PSCR_SM_MSB           3

// system control fields
`define PSCR_DPD_BIT          7
`define PSCR_DSL_BIT          6
`define PSCR_DSE_BIT          5
`define PSCR_PUD_BIT          4
`define PSCR_VSEL_BIT         1
`define PSCR_VCE_BIT          0
`define PSCR_SYS_CTRL_MASK    8'hF3

// clock-gate register 0 fields
`define PSCR_G0_TWI0_BIT      7
`define PSCR_G0_TIM2_BIT      6
`define PSCR_G0_TIM0_BIT      5
`define PSCR_G0_SER1_BIT      4
`define PSCR_G0_TIM1_BIT      3
`define PSCR_G0_SPI0_BIT      2
`define PSCR_G0_SER0_BIT      1
`define PSCR_G0_CONV_BIT      0
// clock-gate register 1 fields
`define PSCR_G1_TIM4_BIT      1
`define PSCR_G1_TIM3_BIT      0
`define PSCR_GATE1_MASK       8'h03
// clock-gate register 2 fields
`define PSCR_G2_TOUCH_BIT     3
`define PSCR_G2_SER2_BIT      2
`define PSCR_G2_SPI1_BIT      1
`define PSCR_GATE2_MASK       8'h0E

// sleep modes
`define PSCR_SM_IDLE          3'h0
`define PSCR_SM_NOISE_RED     3'h1
`define PSCR_SM_POWER_DOWN    3'h2
`define PSCR_SM_POWER_SAVE    3'h3
`define PSCR_SM_RSVD_4        3'h4
`define PSCR_SM_RSVD_5        3'h5
`define PSCR_SM_STANDBY       3'h6
`define PSCR_SM_EXT_STANDBY   3'h7

// timed-sequence windows, in clock cycles
`define PSCR_WIN_CYCLES       4
`define PSCR_DSL_CYCLES       3

`endif

//--- rtl/pscr_timed_seq.v
`timescale 1ns/1ns
// cycle counter for one timed write sequence; live while the window is open
module pscr_timed_seq #(
  parameter LEN = 4
) (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire       arm_i,
  input  wire       cancel_i,
  output wire       live_o,
  output wire       last_o
);
  reg  [3:0] cnt_q;
  reg  [3:0] cnt_d;

  always @* begin
    cnt_d = cnt_q;
    if (arm_i) begin
      cnt_d = LEN[3:0];
    end else if (cancel_i) begin
      cnt_d = 4'h0;
    end else if (cnt_q != 4'h0) begin
      cnt_d = cnt_q - 4'h1;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
    end
  end

  assign live_o = (cnt_q != 4'h0);
  assign last_o = (cnt_q == 4'h1);
endmodule // pscr_timed_seq

//--- rtl/pscr_regs.v
//Contract
// - sleep instruction enters the chosen sleep state only while sleep_enable is one.
// - debug_port_disable one turns debug port off; zero leaves it to the fuse.
// - debug_port_disable changes only after the same value is written twice in four cycles.
// - detector_sleep is set by writing both bits, then sleep-only within four cycles.
// - detector_sleep acts three cycles after set; detector off only if sleeping then.
// - hardware clears detector_sleep three cycles after it became set.
// - pullup_disable one turns off every port pull-up, even pattern 01.
// - vector_select picks vectors at flash start or at the boot section base.
// - vector_select changes only when written within four cycles after change enable.
// - interrupts blocked from change enable until after the next instruction, else four cycles.
// - automatic blocking never touches the global interrupt flag.
// - hardware clears change enable four cycles after write, or on vector_select write.
// - lock bits block interrupts while running from the protected section, when the vectors sit in the other section.
// - gate register 0 bit 7 stops two-wire unit 0; reinitialise after ungating.
// - gate register 0 bit 6 stops timer 2 only in synchronous mode.
// - timers 2, 0, 1, 4, 3 gated by their bits and resume frozen state.
// - gate register 0 bits 4, 2, 1 stop serial 1, spi 0, serial 0.
// - gate register 0 bit 0 stops the converter and denies comparator the mux.
// - gate register 2 bits 3, 2, 1 stop touch unit, serial 2, spi 1.
// - i/o-space accesses answer at data-space offset minus 0x20.
// - sleep_mode_field encodes idle to extended standby; 100 and 101 reserved.
// - a gated peripheral is frozen and its registers are inaccessible.
// - gate register 1 bit 0 also stops two-wire unit 1.
`timescale 1ns/1ns
`include "pscr_defs.vh"
module pscr_regs #(
  parameter BOOT_BASE_0 = 16'h3800,
  parameter BOOT_BASE_1 = 16'h3C00,
  parameter BOOT_BASE_2 = 16'h3E00,
  parameter BOOT_BASE_3 = 16'h3F00
) (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire [7:0] addr_i,
  input  wire       io_space_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  input  wire       sleep_instr_i,
  input  wire       instr_retire_i,
  input  wire       exec_in_boot_i,
  input  wire       timer2_async_select_i,
  input  wire       debug_port_fuse_i,
  input  wire       application_protect_lock_i,
  input  wire       boot_protect_lock_i,
  input  wire [1:0] boot_size_fuses_i,
  output reg        sleep_enter_o,
  output reg  [2:0] sleep_mode_o,
  output reg        detector_off_o,
  output wire       debug_port_enable_o,
  output wire       pullup_disable_o,
  output wire       vector_select_o,
  output reg [15:0] vector_base_o,
  output wire       irq_block_o,
  output wire       gate_two_wire_0_o,
  output wire       gate_two_wire_1_o,
  output wire       gate_timer_0_o,
  output wire       gate_timer_1_o,
  output wire       gate_timer_2_o,
  output wire       gate_timer_3_o,
  output wire       gate_timer_4_o,
  output wire       gate_serial_port_0_o,
  output wire       gate_serial_port_1_o,
  output wire       gate_serial_port_2_o,
  output wire       gate_spi_0_o,
  output wire       gate_spi_1_o,
  output wire       gate_converter_o,
  output wire       comparator_mux_block_o,
  output wire       gate_touch_unit_o
);

  // fuse and lock levels come from pins: two flops before use
  reg  [4:0] pin_meta_q;
  reg  [4:0] pin_sync_q;
  wire       fuse_dbg;
  wire       lock_app;
  wire       lock_boot;
  wire [1:0] boot_size;

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_meta_q <= 5'h00;
      pin_sync_q <= 5'h00;
    end else if (ce_i) begin
      pin_meta_q <= {boot_size_fuses_i, boot_protect_lock_i,
                     application_protect_lock_i, debug_port_fuse_i};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign fuse_dbg  = pin_sync_q[0];
  assign lock_app  = pin_sync_q[1];
  assign lock_boot = pin_sync_q[2];
  assign boot_size = pin_sync_q[4:3];
  // address decode, used for both read and write
  function [2:0] dec_reg;
    input [7:0] a;
    begin
      if (a == `PSCR_OFS_SLEEP_CTRL) begin
        dec_reg = 3'h1;
      end else if (a == `PSCR_OFS_SYS_CTRL) begin
        dec_reg = 3'h2;
      end else if (a == `PSCR_OFS_GATE_0) begin
        dec_reg = 3'h3;
      end else if (a == `PSCR_OFS_GATE_1) begin
        dec_reg = 3'h4;
      end else if (a == `PSCR_OFS_GATE_2) begin
        dec_reg = 3'h5;
      end else begin
        dec_reg = 3'h0;
      end
    end
  endfunction

  wire [7:0] eff_addr;
  wire [2:0] sel;
  wire       wr_slp;
  wire       wr_sys;
  wire       wr_g0;
  wire       wr_g1;
  wire       wr_g2;

  assign eff_addr = io_space_i ? (addr_i + `PSCR_IO_OFFSET) : addr_i;
  assign sel      = dec_reg(eff_addr);
  assign wr_slp   = wr_i && (sel == 3'h1);
  assign wr_sys   = wr_i && (sel == 3'h2);
  assign wr_g0    = wr_i && (sel == 3'h3);
  assign wr_g1    = wr_i && (sel == 3'h4);
  assign wr_g2    = wr_i && (sel == 3'h5);

  localparam [7:0] SLP_RST = `PSCR_RST_SLEEP_CTRL;
  reg  [3:0] slp_q;
  reg        dpd_q;
  reg        dpd_pend_q;
  reg        dsl_q;
  reg        dse_q;
  reg        pud_q;
  reg        vsel_q;
  reg        vce_q;
  reg        vhold_q;
  reg  [7:0] g0_q;
  reg  [1:0] g1_q;
  reg  [2:0] g2_q;
  wire [3:0] seq_live;
  wire [3:0] seq_last;
  wire       dpd_live = seq_live[0];
  wire       dse_live = seq_live[1];
  wire       dse_last = seq_last[1];
  wire       dsl_last = seq_last[2];
  wire       vce_live = seq_live[3];
  wire       vce_last = seq_last[3];

  wire       w_dpd  = wdata_i[`PSCR_DPD_BIT];
  wire       w_dsl  = wdata_i[`PSCR_DSL_BIT];
  wire       w_dse  = wdata_i[`PSCR_DSE_BIT];
  wire       w_vsel = wdata_i[`PSCR_VSEL_BIT];
  wire       w_vce  = wdata_i[`PSCR_VCE_BIT];

  // second matching write inside the window commits; anything else re-arms
  wire       dpd_commit = wr_sys && dpd_live && (w_dpd == dpd_pend_q);
  wire       dpd_arm    = wr_sys && !dpd_commit;
  wire       dse_arm    = wr_sys && w_dsl && w_dse;
  wire       dsl_set    = wr_sys && dse_live && w_dsl && !w_dse;
  wire       vce_arm    = wr_sys && w_vce;
  wire       vsel_wr    = wr_sys && vce_live && !w_vce;

  // one down-counter per timed sequence: debug disable, enable window, detector, vectors
  wire [3:0] seq_arm    = {vce_arm, dsl_set, dse_arm, dpd_arm};
  wire [3:0] seq_cancel = {vsel_wr, 1'b0, dsl_set, dpd_commit};
  genvar     k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_seq
      pscr_timed_seq #(
        .LEN((k == 2) ? `PSCR_DSL_CYCLES : `PSCR_WIN_CYCLES)
      ) u_seq (
        .mclk_i   (mclk_i),
        .rst_n_i  (rst_n_i),
        .ce_i     (ce_i),
        .arm_i    (seq_arm[k]),
        .cancel_i (seq_cancel[k]),
        .live_o   (seq_live[k]),
        .last_o   (seq_last[k])
      );
    end
  endgenerate
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      slp_q      <= SLP_RST[3:0];
      dpd_q      <= 1'b0;
      dpd_pend_q <= 1'b0;
      dsl_q      <= 1'b0;
      dse_q      <= 1'b0;
      pud_q      <= 1'b0;
      vsel_q     <= 1'b0;
      vce_q      <= 1'b0;
      vhold_q    <= 1'b0;
      g0_q       <= `PSCR_RST_GATE;
      g1_q       <= 2'h0;
      g2_q       <= 3'h0;
    end else if (ce_i) begin
      if (wr_slp) begin
        slp_q <= wdata_i[`PSCR_SM_MSB:0];
      end
      if (dpd_commit) begin
        dpd_q <= dpd_pend_q;
      end
      if (dpd_arm) begin
        dpd_pend_q <= w_dpd;
      end
      // the enable bit lives only for its window
      if (dse_arm) begin
        dse_q <= 1'b1;
      end else if (dsl_set || dse_last) begin
        dse_q <= 1'b0;
      end
      if (dsl_set) begin
        dsl_q <= 1'b1;
      end else if (dsl_last) begin
        dsl_q <= 1'b0;
      end
      if (wr_sys) begin
        pud_q <= wdata_i[`PSCR_PUD_BIT];
      end
      if (vsel_wr) begin
        vsel_q <= w_vsel;
      end
      if (vce_arm) begin
        vce_q <= 1'b1;
      end else if (vsel_wr || vce_last) begin
        vce_q <= 1'b0;
      end
      // keep blocking past the instruction that follows the select write
      if (vsel_wr) begin
        vhold_q <= 1'b1;
      end else if (instr_retire_i) begin
        vhold_q <= 1'b0;
      end
      if (wr_g0) begin
        g0_q <= wdata_i;
      end
      if (wr_g1) begin
        g1_q <= wdata_i[1:0];
      end
      if (wr_g2) begin
        g2_q <= wdata_i[3:1];
      end
    end
  end

  // read data is registered; unmapped addresses read zero
  reg  [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (sel == 3'h1) begin
      rd_mux = {4'h0, slp_q};
    end else if (sel == 3'h2) begin
      rd_mux = {dpd_q, dsl_q, dse_q, pud_q, 2'b00, vsel_q, vce_q};
    end else if (sel == 3'h3) begin
      rd_mux = g0_q;
    end else if (sel == 3'h4) begin
      rd_mux = {6'h00, g1_q};
    end else if (sel == 3'h5) begin
      rd_mux = {4'h0, g2_q, 1'b0};
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i && rd_i) begin
      rdata_o <= rd_mux;
    end
  end

  // sleep request; detector turns off only in the third cycle after set
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sleep_enter_o  <= 1'b0;
      sleep_mode_o   <= `PSCR_SM_IDLE;
      detector_off_o <= 1'b0;
    end else if (ce_i) begin
      sleep_enter_o  <= sleep_instr_i && slp_q[`PSCR_SE_BIT];
      sleep_mode_o   <= slp_q[`PSCR_SM_MSB:`PSCR_SM_LSB];
      detector_off_o <= sleep_instr_i && slp_q[`PSCR_SE_BIT] && dsl_last;
    end
  end

  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      vector_base_o <= 16'h0000;
    end else if (ce_i) begin
      if (!vsel_q) begin
        vector_base_o <= 16'h0000;
      end else if (boot_size == 2'h0) begin
        vector_base_o <= BOOT_BASE_0;
      end else if (boot_size == 2'h1) begin
        vector_base_o <= BOOT_BASE_1;
      end else if (boot_size == 2'h2) begin
        vector_base_o <= BOOT_BASE_2;
      end else begin
        vector_base_o <= BOOT_BASE_3;
      end
    end
  end

  // blocking is a separate output so the core's global flag is untouched
  assign irq_block_o = vce_q || vhold_q
                    || (vsel_q && lock_app && !exec_in_boot_i)
                    || (!vsel_q && lock_boot && exec_in_boot_i);

  assign debug_port_enable_o = !dpd_q && fuse_dbg;
  assign pullup_disable_o    = pud_q;
  assign vector_select_o     = vsel_q;

  // gate outputs freeze peripherals and their register access
  assign gate_two_wire_0_o      = g0_q[`PSCR_G0_TWI0_BIT];
  assign gate_timer_2_o         = g0_q[`PSCR_G0_TIM2_BIT] && !timer2_async_select_i;
  assign gate_timer_0_o         = g0_q[`PSCR_G0_TIM0_BIT];
  assign gate_timer_1_o         = g0_q[`PSCR_G0_TIM1_BIT];
  assign gate_serial_port_1_o   = g0_q[`PSCR_G0_SER1_BIT];
  assign gate_spi_0_o           = g0_q[`PSCR_G0_SPI0_BIT];
  assign gate_serial_port_0_o   = g0_q[`PSCR_G0_SER0_BIT];
  assign gate_converter_o       = g0_q[`PSCR_G0_CONV_BIT];
  assign comparator_mux_block_o = g0_q[`PSCR_G0_CONV_BIT];
  assign gate_timer_4_o         = g1_q[`PSCR_G1_TIM4_BIT];
  assign gate_timer_3_o         = g1_q[`PSCR_G1_TIM3_BIT];
  assign gate_two_wire_1_o      = g1_q[`PSCR_G1_TIM3_BIT];
  assign gate_touch_unit_o      = g2_q[2];
  assign gate_serial_port_2_o   = g2_q[1];
  assign gate_spi_1_o           = g2_q[0];

endmodule // pscr_regs

//--- test/pscr_regs_assertions.sv
`timescale 1ns/1ns
`include "pscr_defs.vh"
module pscr_regs_assertions (
  input  wire       mclk_i,
  input  wire       rst_n_i,
  input  wire       ce_i,
  input  wire [7:0] addr_i,
  input  wire       io_space_i,
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] wdata_i,
  input  wire [7:0] rdata_o,
  input  wire       sleep_instr_i,
  input  wire       timer2_async_select_i,
  input  wire       sleep_enter_o,
  input  wire       detector_off_o,
  input  wire       vector_select_o,
  input  wire       irq_block_o,
  input  wire       gate_timer_2_o,
  input  wire       gate_timer_3_o,
  input  wire       gate_two_wire_1_o,
  input  wire       gate_converter_o,
  input  wire       comparator_mux_block_o
);
  wire [7:0] eff = io_space_i ? addr_i + `PSCR_IO_OFFSET : addr_i;
  wire       sys = ce_i && eff == `PSCR_OFS_SYS_CTRL;
  wire       unm = ce_i && eff != 8'h53 && eff != 8'h55 && eff != 8'h63 && eff != 8'h64
                   && eff != 8'h65;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_vce_arm;
    wr_i && sys && wdata_i[0];
  endsequence
  sequence s_sel_write;
    wr_i && sys && !wdata_i[0];
  endsequence
  sleep_cause_a: assert property (sleep_enter_o |-> $past(sleep_instr_i))
    else $error("sleep entered without a sleep instruction");
  detector_with_sleep_a: assert property (detector_off_o |-> sleep_enter_o)
    else $error("detector off outside a sleep entry");
  vce_block_a: assert property (s_vce_arm |=> irq_block_o)
    else $error("interrupts not blocked after change enable");
  vsel_commit_a: assert property (
    s_vce_arm ##2 s_sel_write |=> vector_select_o == $past(wdata_i[1]))
    else $error("vector select not taken inside the window");
  vsel_guard_a: assert property ($changed(vector_select_o) |-> $past(irq_block_o))
    else $error("vector select changed without change enable");
  timer2_sync_a: assert property (
    timer2_async_select_i && $past(timer2_async_select_i) |-> !gate_timer_2_o)
    else $error("timer 2 gated in asynchronous mode");
  conv_mux_a: assert property (comparator_mux_block_o == gate_converter_o)
    else $error("comparator mux block differs from converter gate");
  gate_pair_a: assert property (gate_two_wire_1_o == gate_timer_3_o)
    else $error("two-wire 1 gate differs from its register bit");
  rsvd_read_a: assert property (rd_i && sys |=> rdata_o[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");
  unmapped_read_a: assert property (rd_i && unm |=> rdata_o == 8'h00)
    else $error("unmapped read gave nonzero data");
  rdata_hold_a: assert property (!(rd_i && ce_i) |=> $stable(rdata_o))
    else $error("read data changed without a read");
endmodule // pscr_regs_assertions

//--- test/tb_top.sv
`timescale 1ns/1ns
`include "pscr_defs.vh"
module tb_top;
  localparam [15:0] BB1 = 16'h1A00;
  reg         mclk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [7:0]  addr_i = 8'h00;
  reg         io_space_i = 1'b0;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg  [7:0]  wdata_i = 8'h00;
  reg         slp = 1'b0;
  reg         ret = 1'b0;
  reg         boot = 1'b0;
  reg         t2a = 1'b0;
  reg         fuse = 1'b1;
  reg         alock = 1'b0;
  reg  [1:0]  bsz = 2'h1;
  reg         bl = 1'b0;
  reg         ce = 1'b1;
  wire [7:0]  rdata_o;
  wire [15:0] vbase;
  wire [12:0] g;
  wire [2:0]  smode;
  wire        se_o, doff, dpe, pullup_disable, vsel, blk, cmb, tw1;
  reg  [31:0] seed = 32'h00007216;
  reg  [31:0] v;
  int         n_mismatch = 0;
  int         n_compared = 0;
  int         n_cyc = 0;
  int         i;

  always #20 mclk_i = ~mclk_i;

  pscr_regs #(.BOOT_BASE_1(BB1)) u_pscr_regs (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i),
    .io_space_i(io_space_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
    .rdata_o(rdata_o), .sleep_instr_i(slp), .instr_retire_i(ret), .exec_in_boot_i(boot),
    .timer2_async_select_i(t2a), .debug_port_fuse_i(fuse),
    .application_protect_lock_i(alock), .boot_protect_lock_i(bl),
    .boot_size_fuses_i(bsz), .sleep_enter_o(se_o), .sleep_mode_o(smode),
    .detector_off_o(doff), .debug_port_enable_o(dpe), .pullup_disable_o(pullup_disable),
    .vector_select_o(vsel), .vector_base_o(vbase), .irq_block_o(blk),
    .gate_two_wire_0_o(g[7]), .gate_two_wire_1_o(tw1), .gate_timer_0_o(g[5]),
    .gate_timer_1_o(g[3]), .gate_timer_2_o(g[6]), .gate_timer_3_o(g[8]),
    .gate_timer_4_o(g[9]), .gate_serial_port_0_o(g[1]), .gate_serial_port_1_o(g[4]),
    .gate_serial_port_2_o(g[11]), .gate_spi_0_o(g[2]), .gate_spi_1_o(g[10]),
    .gate_converter_o(g[0]), .comparator_mux_block_o(cmb), .gate_touch_unit_o(g[12])
  );

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  function [15:0] exp_g(input [7:0] g0, input [7:0] g1, input [7:0] g2, input a);
    exp_g = {3'h0, g2[3:1], g1[1:0], g0[7], g0[6] & ~a, g0[5:0]};
  endfunction

  task chk(input string nm, input [15:0] e, input [15:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %s expected %h seen %h", nm, e, got);
      end
    end
  endtask

  task chk_bit(input string nm, input e, input got);
    chk(nm, {15'h0, e}, {15'h0, got});
  endtask

  // low registers are also reached through i/o space at random
  task bus(input w, input r, input [7:0] a, input [7:0] d);
    begin
      seed = xs(seed);
      @(posedge mclk_i);
      wr_i <= w;
      rd_i <= r;
      wdata_i <= d;
      io_space_i <= a < 8'h60 && seed[3];
      addr_i <= (a < 8'h60 && seed[3]) ? a - `PSCR_IO_OFFSET : a;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1;
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      bus(1'b0, 1'b1, a, 8'h00);
      chk("rdata", {8'h00, e}, {8'h00, rdata_o});
    end
  endtask

  task sleep_pulse(input e_enter, input e_off);
    begin
      @(posedge mclk_i);
      slp <= 1'b1;
      @(posedge mclk_i);
      slp <= 1'b0;
      #1;
      chk_bit("sleep_enter", e_enter, se_o);
      chk_bit("detector_off", e_off, doff);
    end
  endtask

  // s picks the level driven: 0 retire, 1 app lock, 2 boot exec, 3 boot lock
  task edge_set(input string nm, input e, input [1:0] s, input val);
    begin
      @(posedge mclk_i);
      if (s == 2'h0) begin
        ret <= val;
      end else if (s == 2'h1) begin
        alock <= val;
      end else if (s == 2'h2) begin
        boot <= val;
      end else begin
        bl <= val;
      end
      repeat (4) @(posedge mclk_i);
      #1;
      chk_bit(nm, e, blk);
    end
  endtask

  task complete_run;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  // generous ceiling: the full sequence needs under 2000 cycles
  always @(posedge mclk_i) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      complete_run;
    end
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(8'h53, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h64, 8'h00);
    chk_bit("debug_enable", 1'b1, dpe);
    bus(1'b1, 1'b0, 8'h54, 8'hFF);
    rd(8'h54, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      seed = xs(seed);
      v = (i == 0) ? 32'h01FFFFFF : (i == 1) ? 32'h0 : seed;
      t2a <= v[24];
      bus(1'b1, 1'b0, 8'h63, v[7:0]);
      bus(1'b1, 1'b0, 8'h64, v[15:8]);
      bus(1'b1, 1'b0, 8'h65, v[23:16]);
      chk("gates", exp_g(v[15:8], v[23:16], v[7:0], v[24]), {3'h0, g});
      chk_bit("mux_block", v[8], cmb);
      chk_bit("two_wire_1", v[16], tw1);
      rd(8'h63, v[7:0] & `PSCR_GATE2_MASK);
      rd(8'h64, v[15:8]);
      rd(8'h65, v[23:16] & `PSCR_GATE1_MASK);
    end
    // a write with the clock enable low must leave every gate as it was
    ce <= 1'b0;
    bus(1'b1, 1'b0, 8'h64, ~v[15:8]);
    chk("gates", exp_g(v[15:8], v[23:16], v[7:0], v[24]), {3'h0, g});
    ce <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      bus(1'b1, 1'b0, 8'h53, {4'hF, i[2:0], 1'b1});
      sleep_pulse(1'b1, 1'b0);
      chk("sleep_mode", {13'h0, i[2:0]}, {13'h0, smode});
    end
    bus(1'b1, 1'b0, 8'h53, 8'h0E);
    sleep_pulse(1'b0, 1'b0);
    rd(8'h53, 8'h0E);
    bus(1'b1, 1'b0, 8'h55, 8'h1C);
    chk_bit("pullup", 1'b1, pullup_disable);
    rd(8'h55, 8'h10);
    bus(1'b1, 1'b0, 8'h55, 8'h80);
    repeat (6) @(posedge mclk_i);
    chk_bit("debug_enable", 1'b1, dpe);
    bus(1'b1, 1'b0, 8'h55, 8'h80);
    bus(1'b1, 1'b0, 8'h55, 8'h80);
    chk_bit("debug_enable", 1'b0, dpe);
    chk_bit("pullup", 1'b0, pullup_disable);
    bus(1'b1, 1'b0, 8'h55, 8'h00);
    bus(1'b1, 1'b0, 8'h55, 8'h00);
    chk_bit("debug_enable", 1'b1, dpe);
    bus(1'b1, 1'b0, 8'h55, 8'h02);
    chk_bit("vector_select", 1'b0, vsel);
    bus(1'b1, 1'b0, 8'h55, 8'h01);
    chk_bit("irq_block", 1'b1, blk);
    bus(1'b1, 1'b0, 8'h55, 8'h02);
    chk_bit("vector_select", 1'b1, vsel);
    // the vector base is registered from the select bit: one edge later
    @(posedge mclk_i);
    #1;
    chk("vector_base", BB1, vbase);
    chk_bit("irq_block", 1'b1, blk);
    edge_set("irq_block", 1'b0, 2'h0, 1'b1);
    ret <= 1'b0;
    bus(1'b1, 1'b0, 8'h55, 8'h01);
    repeat (6) @(posedge mclk_i);
    rd(8'h55, 8'h02);
    chk_bit("irq_block", 1'b0, blk);
    edge_set("irq_block", 1'b1, 2'h1, 1'b1);
    edge_set("irq_block", 1'b0, 2'h2, 1'b1);
    alock <= 1'b0;
    bus(1'b1, 1'b0, 8'h55, 8'h01);
    bus(1'b1, 1'b0, 8'h55, 8'h00);
    @(posedge mclk_i);
    #1;
    chk("vector_base", 16'h0000, vbase);
    edge_set("irq_block", 1'b0, 2'h0, 1'b1);
    ret <= 1'b0;
    edge_set("irq_block", 1'b1, 2'h3, 1'b1);
    edge_set("irq_block", 1'b0, 2'h2, 1'b0);
    bus(1'b1, 1'b0, 8'h53, 8'h01);
    bus(1'b1, 1'b0, 8'h55, 8'h40);
    rd(8'h55, 8'h00);
    for (i = 0; i < 3; i = i + 1) begin
      bus(1'b1, 1'b0, 8'h55, 8'h60);
      bus(1'b1, 1'b0, 8'h55, 8'h40);
      repeat (i) @(posedge mclk_i);
      sleep_pulse(1'b1, i == 1);
      repeat (4) @(posedge mclk_i);
      rd(8'h55, 8'h00);
    end
    complete_run;
  end
endmodule // tb_top

bind pscr_regs pscr_regs_assertions u_pscr_regs_assertions (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
  .io_space_i(io_space_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
  .rdata_o(rdata_o), .sleep_instr_i(sleep_instr_i),
  .timer2_async_select_i(timer2_async_select_i), .sleep_enter_o(sleep_enter_o),
  .detector_off_o(detector_off_o), .vector_select_o(vector_select_o),
  .irq_block_o(irq_block_o), .gate_timer_2_o(gate_timer_2_o),
  .gate_timer_3_o(gate_timer_3_o), .gate_two_wire_1_o(gate_two_wire_1_o),
  .gate_converter_o(gate_converter_o), .comparator_mux_block_o(comparator_mux_block_o)
);
